/* mfl_loader.sv */
// master flash configuration loader, serial and parallel front end
`timescale 1ns/1ps
`include "mfl_consts.svh"
module mfl_loader
   import mfl_pkg::*;
#(
   parameter int CONFIG_CLOCK_HALF       = `MFL_CONFIG_CLOCK_HALF_CYC,
   parameter int CLEAR_CYC       = `MFL_CLEAR_CYC,
   parameter int SYNC_WAIT_BYTES = `MFL_SYNC_WAIT_BYTES
)(
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic        clk_en,
   input  wire logic        program_n_pin,
   input  wire logic        init_n_in,
   output logic             init_n_out,
   output logic             init_n_oe,
   input  wire logic [1:0]  mode_pins,
   input  wire logic        multi_image_boot,
   input  wire logic [7:0]  boot_read_cmd,
   input  wire logic        internal_reprogram_cmd,
   input  wire logic [7:0]  reprog_read_cmd,
   input  wire logic        sync_found,
   input  wire logic        sync_wide,
   input  wire logic        config_done,
   output logic             config_clock,
   output logic             spi_select_n,
   output logic             spi_mosi_out,
   output logic             spi_mosi_oe,
   input  wire logic [3:0]  spi_dq_in,
   output logic [25:0]      flash_addr,
   output logic             flash_select_n,
   output logic             flash_output_enable_n,
   output logic             flash_write_enable_n,
   input  wire logic [15:0] flash_data_in,
   output logic [15:0]      data_word,
   output logic             data_valid,
   output logic             data_is_x16,
   output logic             parallel_flash_mode,
   output logic             loader_busy
);

   generate
      if (CONFIG_CLOCK_HALF < 1 || CONFIG_CLOCK_HALF > 65535)
      begin : g_bad_half
         $error("CONFIG_CLOCK_HALF out of range");
      end
      if (CLEAR_CYC < 1 || CLEAR_CYC > 65535)
      begin : g_bad_clear
         $error("CLEAR_CYC out of range");
      end
      if (SYNC_WAIT_BYTES < 1 || SYNC_WAIT_BYTES > 65535)
      begin : g_bad_wait
         $error("SYNC_WAIT_BYTES out of range");
      end
   endgenerate

   localparam logic [15:0] HALF_M1 = 16'(CONFIG_CLOCK_HALF - 1);
   localparam logic [15:0] CLR_M1  = 16'(CLEAR_CYC - 1);
   localparam logic [15:0] WAIT_M1 = 16'(SYNC_WAIT_BYTES - 1);

   // width of the returned data for a given read command
   function automatic mfl_width_e cmd_width(input logic [7:0] cmd);
      if (cmd == `MFL_CMD_DUAL)
         return MFL_W2;
      else if (cmd == `MFL_CMD_QUAD)
         return MFL_W4;
      else
         return MFL_W1;
   endfunction

   // dummy clocks between address and data
   function automatic logic [5:0] cmd_dummy(input logic [7:0] cmd);
      if (cmd == `MFL_CMD_FAST || cmd == `MFL_CMD_DUAL ||
          cmd == `MFL_CMD_QUAD)
         return `MFL_FAST_DUMMY;
      else if (cmd == `MFL_CMD_READ_ALT)
         return `MFL_ALT_DUMMY;
      else
         return `MFL_NO_DUMMY;
   endfunction

   // candidate list walked during the initial load
   function automatic logic [7:0] cand_cmd(input logic idx);
      return idx ? `MFL_CMD_READ_ALT : `MFL_CMD_READ;
   endfunction

   mfl_state_e                state_q;
   logic [`MFL_SYN_W-1:0]     s1_q;
   logic [`MFL_SYN_W-1:0]     s2_q;
   logic [`MFL_SYN_W-1:0]     s3_q;
   logic [`MFL_SYN_W-1:0]     filt_q;
   logic [`MFL_SYN_W-1:0]     pins_raw;
   logic [`MFL_SYN_W-1:0]     pins_f;
   logic [15:0]               div_q;
   logic [15:0]               clr_cnt_q;
   logic [7:0]                cmd_q;
   logic                      loop_q;
   logic                      cand_q;
   logic [31:0]               shreg_q;
   logic [5:0]                hdr_left_q;
   logic [5:0]                dummy_left_q;
   logic [3:0]                bit_cnt_q;
   logic [7:0]                byte_q;
   logic [15:0]               byte_cnt_q;
   logic                      synced_q;
   logic                      width_known_q;
   logic                      run;
   logic                      tick;
   logic                      rise_ev;
   logic                      fall_ev;
   logic                      prog_f;
   logic                      init_f;
   logic [1:0]                mode_f;
   logic [3:0]                dq_f;
   logic [15:0]               data_f;
   mfl_width_e                cur_w;
   logic [3:0]                lanes;
   logic [3:0]                bit_next;
   logic [7:0]                byte_next;
   logic                      byte_done;
   logic                      retry;

   // pins pass three flops; a change counts once stages two and three agree
   assign pins_raw = {flash_data_in, spi_dq_in, mode_pins, init_n_in,
                      program_n_pin};

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end
      else if (clk_en)
      begin
         s1_q <= pins_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < `MFL_SYN_W; gi++)
      begin : g_filt
         always_ff @(posedge mclk)
         begin
            if (sys_rst)
               filt_q[gi] <= 1'h0;
            else if (clk_en && s2_q[gi] == s3_q[gi])
               filt_q[gi] <= s3_q[gi];
         end
      end
   endgenerate

   // agreeing stages count at once: the sample tick comes four cycles
   // after a far-side change, so a fourth flop would read stale data
   assign pins_f = (s3_q & ~(s2_q ^ s3_q)) | (filt_q & (s2_q ^ s3_q));

   assign prog_f = pins_f[`MFL_SYN_PROG];
   assign init_f = pins_f[`MFL_SYN_INIT];
   assign mode_f = pins_f[`MFL_SYN_MODE +: 2];
   assign dq_f   = pins_f[`MFL_SYN_DQ +: 4];
   assign data_f = pins_f[`MFL_SYN_DATA +: 16];

   // configuration clock, divided down and only running while reading
   assign run = (state_q == MFL_ST_SPI_CMD) || (state_q == MFL_ST_SPI_RX) ||
                (state_q == MFL_ST_SPI_GAP) || (state_q == MFL_ST_PAR);
   assign tick    = run && (div_q == HALF_M1);
   assign rise_ev = tick && !config_clock;
   assign fall_ev = tick && config_clock;

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         div_q        <= 16'h0000;
         config_clock <= 1'h0;
      end
      else if (clk_en)
      begin
         if (!run)
         begin
            div_q        <= 16'h0000;
            config_clock <= 1'h0;
         end
         else if (tick)
         begin
            div_q        <= 16'h0000;
            config_clock <= ~config_clock;
         end
         else
            div_q <= div_q + 16'h0001;
      end
   end

   assign cur_w = cmd_width(cmd_q);

   // receive lanes: x1 on DO, x2 on DO and MOSI, x4 on all four
   always_comb
   begin
      lanes     = 4'h0;
      bit_next  = bit_cnt_q;
      byte_next = byte_q;
      unique case (cur_w)
         MFL_W1:
         begin
            byte_next = {byte_q[6:0], dq_f[1]};
            bit_next  = bit_cnt_q + 4'h1;
         end
         MFL_W2:
         begin
            byte_next = {byte_q[5:0], dq_f[1], dq_f[0]};
            bit_next  = bit_cnt_q + 4'h2;
         end
         MFL_W4:
         begin
            lanes     = dq_f;
            byte_next = {byte_q[3:0], lanes};
            bit_next  = bit_cnt_q + 4'h4;
         end
      endcase
   end

   assign byte_done = rise_ev && (state_q == MFL_ST_SPI_RX) &&
                      (bit_next == 4'h8);
   // no sync word within the wait window: move to the next candidate
   assign retry = byte_done && loop_q && !synced_q && !sync_found &&
                  (byte_cnt_q == WAIT_M1);

   // sequencing; program low or a reprogram command restart everything
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         state_q <= MFL_ST_IDLE;
      else if (clk_en)
      begin
         if (!prog_f)
            state_q <= MFL_ST_IDLE;
         else if (internal_reprogram_cmd)
            state_q <= MFL_ST_CLEAR;
         else
         begin
            unique case (state_q)
               MFL_ST_IDLE:
                  state_q <= MFL_ST_CLEAR;
               MFL_ST_CLEAR:
                  if (clr_cnt_q == CLR_M1)
                     state_q <= MFL_ST_WAIT_INIT;
               MFL_ST_WAIT_INIT:
                  if (init_f)
                     state_q <= MFL_ST_SAMPLE;
               MFL_ST_SAMPLE:
                  if (mode_f == `MFL_MODE_PAR)
                     state_q <= MFL_ST_PAR;
                  else if (mode_f == `MFL_MODE_SPI)
                     state_q <= MFL_ST_SPI_CMD;
                  else
                     state_q <= MFL_ST_DONE;
               MFL_ST_SPI_CMD:
                  if (fall_ev && !spi_select_n && hdr_left_q == 6'h00 &&
                      dummy_left_q == 6'h00)
                     state_q <= MFL_ST_SPI_RX;
               MFL_ST_SPI_RX:
                  if (config_done)
                     state_q <= MFL_ST_DONE;
                  else if (retry)
                     state_q <= MFL_ST_SPI_GAP;
               MFL_ST_SPI_GAP:
                  if (fall_ev)
                     state_q <= MFL_ST_SPI_CMD;
               MFL_ST_PAR:
                  if (config_done)
                     state_q <= MFL_ST_DONE;
               MFL_ST_DONE:
                  state_q <= MFL_ST_DONE;
            endcase
         end
      end
   end

   // init drive-low window, the memory clear phase
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         clr_cnt_q  <= 16'h0000;
         init_n_oe  <= 1'h0;
         init_n_out <= 1'h0;
      end
      else if (clk_en)
      begin
         init_n_out <= 1'h0;
         init_n_oe  <= (state_q == MFL_ST_CLEAR);
         if (state_q == MFL_ST_CLEAR)
            clr_cnt_q <= clr_cnt_q + 16'h0001;
         else
            clr_cnt_q <= 16'h0000;
      end
   end

   // read command choice: loop, explicit boot setting, or reprogram
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         cmd_q  <= `MFL_CMD_READ;
         loop_q <= 1'h1;
         cand_q <= 1'h0;
      end
      else if (clk_en)
      begin
         if (!prog_f)
         begin
            loop_q <= 1'h1;
            cand_q <= 1'h0;
            cmd_q  <= `MFL_CMD_READ;
         end
         else if (internal_reprogram_cmd)
         begin
            cmd_q  <= reprog_read_cmd;
            loop_q <= 1'h0;
         end
         else if (state_q == MFL_ST_SAMPLE && loop_q)
         begin
            if (multi_image_boot)
            begin
               cmd_q  <= boot_read_cmd;
               loop_q <= 1'h0;
            end
            else
            begin
               cmd_q  <= cand_cmd(1'h0);
               cand_q <= 1'h0;
            end
         end
         else if (retry)
         begin
            cmd_q  <= cand_cmd(~cand_q);
            cand_q <= ~cand_q;
         end
      end
   end

   // serial command, address and dummy phase, all driven on falling edges
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         spi_select_n <= 1'h1;
         spi_mosi_out <= 1'h0;
         spi_mosi_oe  <= 1'h0;
         shreg_q      <= 32'h00000000;
         hdr_left_q   <= 6'h00;
         dummy_left_q <= 6'h00;
      end
      else if (clk_en)
      begin
         if (!run || state_q == MFL_ST_PAR)
         begin
            spi_select_n <= 1'h1;
            spi_mosi_oe  <= 1'h0;
         end
         else if (fall_ev)
         begin
            if (state_q == MFL_ST_SPI_GAP)
            begin
               spi_select_n <= 1'h1;
               spi_mosi_oe  <= 1'h0;
            end
            else if (state_q == MFL_ST_SPI_CMD && spi_select_n)
            begin
               // flash must already be awake here, no wake-up wait
               spi_select_n <= 1'h0;
               spi_mosi_oe  <= 1'h1;
               spi_mosi_out <= cmd_q[7];
               shreg_q      <= {cmd_q[6:0], `MFL_SPI_ADDR, 1'h0};
               hdr_left_q   <= `MFL_HDR_BITS;
               dummy_left_q <= cmd_dummy(cmd_q);
            end
            else if (hdr_left_q != 6'h00)
            begin
               spi_mosi_out <= shreg_q[31];
               shreg_q      <= {shreg_q[30:0], 1'h0};
               hdr_left_q   <= hdr_left_q - 6'h01;
            end
            else
            begin
               // wide reads hand the MOSI line to the flash
               if (cur_w != MFL_W1)
                  spi_mosi_oe <= 1'h0;
               spi_mosi_out <= 1'h0;
               if (dummy_left_q != 6'h00)
                  dummy_left_q <= dummy_left_q - 6'h01;
            end
         end
      end
   end

   // serial receive, one bit group per rising edge
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         bit_cnt_q  <= 4'h0;
         byte_q     <= 8'h00;
         byte_cnt_q <= 16'h0000;
      end
      else if (clk_en)
      begin
         if (state_q != MFL_ST_SPI_RX)
         begin
            bit_cnt_q  <= 4'h0;
            byte_cnt_q <= 16'h0000;
         end
         else if (rise_ev)
         begin
            byte_q <= byte_next;
            if (byte_done)
            begin
               bit_cnt_q  <= 4'h0;
               byte_cnt_q <= byte_cnt_q + 16'h0001;
            end
            else
               bit_cnt_q <= bit_next;
         end
      end
   end

   // sync seen in this pass; a sync in the clearing cycle still wins
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         synced_q <= 1'h0;
      else if (clk_en)
         synced_q <= sync_found || (synced_q &&
                     (state_q == MFL_ST_SPI_RX || state_q == MFL_ST_PAR));
   end

   // parallel address: zero at entry, +1 per falling edge, wraps
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         flash_addr <= `MFL_ADDR_START;
      else if (clk_en)
      begin
         if (state_q != MFL_ST_PAR)
            flash_addr <= `MFL_ADDR_START;
         else if (fall_ev)
            flash_addr <= flash_addr + 26'h0000001;
      end
   end

   // parallel control pins, reads only
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         flash_select_n        <= 1'h1;
         flash_output_enable_n <= 1'h1;
         flash_write_enable_n  <= 1'h1;
      end
      else if (clk_en)
      begin
         flash_select_n        <= (state_q != MFL_ST_PAR);
         flash_output_enable_n <= (state_q != MFL_ST_PAR);
         flash_write_enable_n  <= 1'h1;
      end
   end

   // parallel width: full word until the sync word tells which lanes
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         width_known_q <= 1'h0;
         data_is_x16   <= 1'h0;
      end
      else if (clk_en)
      begin
         if (state_q != MFL_ST_PAR)
         begin
            width_known_q <= 1'h0;
            data_is_x16   <= 1'h0;
         end
         else if (sync_found && !width_known_q)
         begin
            width_known_q <= 1'h1;
            data_is_x16   <= sync_wide;
         end
      end
   end

   // data stream out; chained images pass straight to the parser
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         data_word  <= 16'h0000;
         data_valid <= 1'h0;
      end
      else if (clk_en)
      begin
         data_valid <= 1'h0;
         if (byte_done)
         begin
            data_word  <= {8'h00, byte_next};
            data_valid <= 1'h1;
         end
         else if (state_q == MFL_ST_PAR && rise_ev)
         begin
            if (width_known_q && !data_is_x16)
               data_word <= {8'h00, data_f[7:0]};
            else
               data_word <= data_f;
            data_valid <= 1'h1;
         end
      end
   end

   // status
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         parallel_flash_mode <= 1'h0;
         loader_busy         <= 1'h0;
      end
      else if (clk_en)
      begin
         if (state_q == MFL_ST_SAMPLE)
            parallel_flash_mode <= (mode_f == `MFL_MODE_PAR);
         loader_busy <= (state_q != MFL_ST_DONE);
      end
   end

endmodule // mfl_loader

/* mfl_consts.svh */
// constants for the master flash configuration loader
`ifndef MFL_CONSTS_SVH
`define MFL_CONSTS_SVH
`define MFL_CLK_MHZ          20
`define MFL_CONFIG_CLOCK_HALF_NS     200
`define MFL_CLEAR_NS         1000
`define MFL_CONFIG_CLOCK_HALF_CYC    ((`MFL_CONFIG_CLOCK_HALF_NS*`MFL_CLK_MHZ)/1000)
`define MFL_CLEAR_CYC        ((`MFL_CLEAR_NS*`MFL_CLK_MHZ+999)/1000)
`define MFL_SYNC_WAIT_BYTES  64
`define MFL_CMD_READ         8'h03
`define MFL_CMD_READ_ALT     8'hE8
`define MFL_CMD_FAST         8'h0B
`define MFL_CMD_DUAL         8'h3B
`define MFL_CMD_QUAD         8'h6B
`define MFL_FAST_DUMMY       6'h08
`define MFL_ALT_DUMMY        6'h20
`define MFL_NO_DUMMY         6'h00
`define MFL_HDR_BITS         6'h1F
`define MFL_SPI_ADDR         24'h000000
`define MFL_MODE_PAR         2'h0
`define MFL_MODE_SPI         2'h1
`define MFL_ADDR_START       26'h0000000
`define MFL_SYN_PROG         0
`define MFL_SYN_INIT         1
`define MFL_SYN_MODE         2
`define MFL_SYN_DQ           4
`define MFL_SYN_DATA         8
`define MFL_SYN_W            24
`endif

/* mfl_pkg.sv */
// types for the master flash configuration loader
package mfl_pkg;
   typedef enum logic [3:0] {
      MFL_ST_IDLE,
      MFL_ST_CLEAR,
      MFL_ST_WAIT_INIT,
      MFL_ST_SAMPLE,
      MFL_ST_SPI_CMD,
      MFL_ST_SPI_RX,
      MFL_ST_SPI_GAP,
      MFL_ST_PAR,
      MFL_ST_DONE
   } mfl_state_e;

   typedef enum logic [1:0] {
      MFL_W1,
      MFL_W2,
      MFL_W4
   } mfl_width_e;
endpackage

/* mfl_loader_props.sv */
// concurrent checks on the loader's pins
`timescale 1ns/1ps
module mfl_loader_props (
   input wire logic        mclk,
   input wire logic        sys_rst,
   input wire logic        program_n_pin,
   input wire logic        init_n_in,
   input wire logic        config_clock,
   input wire logic        spi_select_n,
   input wire logic        spi_mosi_out,
   input wire logic [25:0] flash_addr,
   input wire logic        flash_select_n,
   input wire logic        flash_output_enable_n,
   input wire logic        flash_write_enable_n,
   input wire logic        data_valid,
   input wire logic        parallel_flash_mode
);
   default clocking dc @(posedge mclk);
   endclocking
   default disable iff (sys_rst);
   we_high_a: assert property (flash_write_enable_n)
      else $error("flash write enable low");
   par_sel_a: assert property (!flash_select_n |->
      parallel_flash_mode && !flash_output_enable_n)
      else $error("flash select outside parallel read");
   addr_step_a: assert property (!flash_select_n &&
      !$past(flash_select_n) && $changed(flash_addr) |->
      flash_addr == $past(flash_addr) + 26'h0000001)
      else $error("address did not step by one");
   addr_fall_a: assert property (!flash_select_n &&
      $changed(flash_addr) |-> $fell(config_clock))
      else $error("address moved off a falling clock");
   par_sample_a: assert property (data_valid &&
      parallel_flash_mode |-> config_clock && !$past(config_clock))
      else $error("parallel word not after a rising clock");
   spi_edge_a: assert property ($fell(spi_select_n) ||
      (!spi_select_n && $changed(spi_mosi_out)) |-> $fell(config_clock))
      else $error("select or mosi moved off a falling clock");
   prog_hold_a: assert property ((!program_n_pin)[*8] |->
      spi_select_n && flash_select_n)
      else $error("flash selected while program held");
   init_hold_a: assert property ((!init_n_in)[*8] |->
      spi_select_n && flash_select_n)
      else $error("flash selected while init held");
endmodule // mfl_loader_props
bind mfl_loader mfl_loader_props u_props (.mclk, .sys_rst, .program_n_pin,
   .init_n_in, .config_clock, .spi_select_n, .spi_mosi_out, .flash_addr,
   .flash_select_n, .flash_output_enable_n, .flash_write_enable_n,
   .data_valid, .parallel_flash_mode);

/* mfl_flash_model.sv */
// behavioural serial and parallel flash on the loader's far side
`timescale 1ns/1ps
`include "mfl_consts.svh"
module mfl_flash_model (
   input  wire logic        config_clock,
   input  wire logic        spi_select_n,
   input  wire logic        spi_mosi_out,
   input  wire logic        spi_mosi_oe,
   input  wire logic [7:0]  byte_val,
   output logic      [3:0]  spi_dq_in,
   input  wire logic [25:0] flash_addr,
   input  wire logic        flash_select_n,
   input  wire logic        flash_output_enable_n,
   output logic      [15:0] flash_data_in,
   output logic      [31:0] hdr,
   output logic             hdr_tgl,
   output logic             early_sel
);
   logic [31:0] sh;
   logic [3:0]  d;
   logic [7:0]  v;
   logic        awake;
   int          cnt, ph, w, dum;
   initial
   begin
      {sh, hdr, d, hdr_tgl, early_sel, awake} = '0;
      {cnt, ph, w, dum} = {32'd0, 32'd0, 32'd1, 32'd0};
      flash_data_in = 16'h0000;
      #2000 awake = 1'b1; // power-up quiet time
   end
   // io0 is shared: loader's mosi wins while it drives
   assign spi_dq_in = {d[3:1], spi_mosi_oe ? spi_mosi_out : d[0]};
   always @(negedge spi_select_n)
   begin
      cnt = 0;
      ph = 0;
      if (!awake) early_sel = 1'b1;
   end
   // released lines flip so stale data never looks valid
   always @(posedge spi_select_n)
      d = ~d;
   always @(posedge config_clock)
      if (!spi_select_n)
      begin
         if (cnt < 32) sh = {sh[30:0], spi_dq_in[0]};
         cnt = cnt + 1;
         if (cnt == 32)
         begin
            hdr = sh;
            hdr_tgl = ~hdr_tgl;
            dum = (sh[31:24] == `MFL_CMD_READ) ? 0 :
                  (sh[31:24] == `MFL_CMD_READ_ALT) ? 32 : 8;
            w = (sh[31:24] == `MFL_CMD_DUAL) ? 2 :
                (sh[31:24] == `MFL_CMD_QUAD) ? 4 : 1;
         end
      end
   always @(negedge config_clock)
      if (!spi_select_n && cnt >= 32 + dum)
      begin
         v = byte_val << (ph * w);
         if (w == 1) d[1] = v[7];
         else if (w == 2) d[1:0] = v[7:6];
         else d = v[7:4];
         ph = (ph + 1) % (8 / w);
      end
   // async read: data follows address while selected
   always @(flash_addr or flash_select_n or flash_output_enable_n)
      flash_data_in = (!flash_select_n && !flash_output_enable_n) ?
                      {~flash_addr[7:0], flash_addr[7:0]} : ~flash_data_in;
endmodule // mfl_flash_model

/* mfl_loader_tb.sv */
// self-checking bench for the master flash configuration loader
`timescale 1ns/1ps
`include "mfl_consts.svh"
module mfl_loader_tb import mfl_pkg::*;;
   logic        mclk, sys_rst, program_n_pin, init_hold, multi_image_boot;
   logic        internal_reprogram_cmd, sync_found, sync_wide, config_done;
   logic        init_n_out, init_n_oe, init_n_in, config_clock, spi_select_n;
   logic        spi_mosi_out, spi_mosi_oe, flash_select_n, data_valid;
   logic        flash_output_enable_n, flash_write_enable_n, data_is_x16;
   logic        parallel_flash_mode, loader_busy, hdr_tgl, early_sel, wb;
   logic [1:0]  mode_pins;
   logic [7:0]  boot_read_cmd, reprog_read_cmd, byte_val;
   logic [3:0]  spi_dq_in;
   logic [25:0] flash_addr;
   logic [15:0] flash_data_in, data_word, mask;
   logic [31:0] hdr;
   logic [15:0] exp_q[$];
   logic [7:0]  op_q[$];
   int          bad_count, checks_done, seed;
   // open-drain init with pull-up
   assign init_n_in = !(init_hold || (init_n_oe && !init_n_out));
   mfl_loader #(.CONFIG_CLOCK_HALF(4), .CLEAR_CYC(20), .SYNC_WAIT_BYTES(4)) dut (
      .mclk, .sys_rst, .clk_en(1'b1), .program_n_pin, .init_n_in,
      .init_n_out, .init_n_oe, .mode_pins, .multi_image_boot, .boot_read_cmd,
      .internal_reprogram_cmd, .reprog_read_cmd, .sync_found, .sync_wide,
      .config_done, .config_clock, .spi_select_n, .spi_mosi_out,
      .spi_mosi_oe, .spi_dq_in, .flash_addr, .flash_select_n,
      .flash_output_enable_n, .flash_write_enable_n, .flash_data_in,
      .data_word, .data_valid, .data_is_x16, .parallel_flash_mode,
      .loader_busy);
   mfl_flash_model u_flash (.config_clock, .spi_select_n, .spi_mosi_out,
      .spi_mosi_oe, .byte_val, .spi_dq_in, .flash_addr, .flash_select_n,
      .flash_output_enable_n, .flash_data_in, .hdr, .hdr_tgl, .early_sel);
   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   task automatic results;
      if (bad_count == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic fail(input string msg);
      bad_count++;
      $display("MISMATCH %0t %s", $time, msg);
   endtask
   task automatic chk(input logic ok, input string msg);
      checks_done++;
      if (ok !== 1'b1) fail(msg);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask
   // bounded wait until every noted result has been seen
   task automatic wait_q;
      int k;
      k = 0;
      while ((exp_q.size() > 0 || op_q.size() > 0) && k < 6000)
      begin
         cyc(1);
         k++;
      end
      if (k >= 6000) fail("results missing");
   endtask
   task automatic pulse_sync(input logic wide);
      sync_wide = wide;
      sync_found = 1'b1;
      cyc(1);
      sync_found = 1'b0;
   endtask
   task automatic session(input logic [7:0] op, input int n, input logic s);
      op_q.push_back(op);
      repeat (n) exp_q.push_back({8'h00, byte_val});
      wait_q();
      if (s) pulse_sync(1'b0);
   endtask
   task automatic reprog(input logic [7:0] op);
      reprog_read_cmd = op;
      internal_reprogram_cmd = 1'b1;
      cyc(1);
      internal_reprogram_cmd = 1'b0;
      cyc(4);
      chk(init_n_oe && !init_n_out && loader_busy, "no clear phase");
      session(op, 3, 1'b1);
      chk(spi_mosi_oe === 1'b0, "mosi still driven");
   endtask
   always @(posedge mclk)
      if (data_valid === 1'b1 && exp_q.size() > 0)
         chk((data_word & mask) === exp_q.pop_front(), "data word");
   always @(hdr_tgl)
      if ($time > 0)
      begin
         if (op_q.size() == 0) fail("unexpected read command");
         else chk(hdr === {op_q.pop_front(), 24'h000000}, "cmd");
      end
   initial
   begin
      #3000000;
      fail("watchdog");
      results();
   end
   initial
   begin
      {sys_rst, init_hold, program_n_pin, multi_image_boot} = 4'b1100;
      {internal_reprogram_cmd, sync_found, sync_wide, config_done} = 4'h0;
      {bad_count, checks_done, seed} = {32'd0, 32'd0, 32'd51};
      mode_pins = `MFL_MODE_SPI;
      boot_read_cmd = `MFL_CMD_FAST;
      reprog_read_cmd = 8'h00;
      mask = 16'h00FF;
      byte_val = 8'($random(seed));
      cyc(5);
      sys_rst = 1'b0;
      cyc(40);
      program_n_pin = 1'b1; // flash awake by now
      cyc(60);
      chk(spi_select_n === 1'b1, "started under init");
      init_hold = 1'b0;
      session(`MFL_CMD_READ, 4, 1'b0);
      session(`MFL_CMD_READ_ALT, 2, 1'b1);
      cyc(600);
      reprog(`MFL_CMD_DUAL);
      reprog(`MFL_CMD_QUAD);
      multi_image_boot = 1'b1;
      program_n_pin = 1'b0;
      cyc(12);
      program_n_pin = 1'b1;
      session(`MFL_CMD_FAST, 2, 1'b1);
      {multi_image_boot, program_n_pin, mask} = {2'b00, 16'hFFFF};
      mode_pins = `MFL_MODE_PAR;
      cyc(12);
      program_n_pin = 1'b1;
      for (int k = 0; k < 3000 && data_valid !== 1'b1; k++) cyc(1);
      cyc(1);
      chk(parallel_flash_mode === 1'b1, "mode");
      chk(!flash_output_enable_n && flash_write_enable_n, "pins");
      for (int n = 1; n < 7; n++) exp_q.push_back({~n[7:0], n[7:0]});
      wait_q();
      wb = 1'($random(seed));
      pulse_sync(wb);
      cyc(3);
      chk(data_is_x16 === wb, "bus width");
      config_done = 1'b1;
      cyc(8);
      chk(flash_select_n && !loader_busy, "reading after done");
      chk(early_sel === 1'b0, "flash selected asleep");
      {program_n_pin, mode_pins} = 3'b011;
      cyc(12);
      program_n_pin = 1'b1;
      cyc(60);
      chk(!loader_busy && spi_select_n && flash_select_n, "mode 11");
      results();
   end
endmodule // mfl_loader_tb
